// ### hw/pisp_pkg.sv
// Constants and types shared by the host-side two-wire bus master
`default_nettype none

package pisp_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Timing

   // System clock period in ns
   localparam int CLK_PERIOD_NS = 10;
   // Highest bit rate the device accepts, in kbit/s
   localparam int MAX_RATE_KBPS = 400;
   // Shortest legal bit period in ns
   localparam int BIT_PERIOD_NS = 1000000 / MAX_RATE_KBPS;
   // Quarter bit in cycles, rounded up so the rate never exceeds the max
   localparam int QUARTER_CYCLES =
      (BIT_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

   ////////////////////////////////////////////////////////////////////////
   // Bit slots and protocol values

   // Slot index of the acknowledge clock, after eight data slots
   localparam logic [3:0] ACK_SLOT   = 4'h8;
   localparam logic [3:0] FIRST_SLOT = 4'h0;
   localparam logic [3:0] SLOT_STEP  = 4'h1;
   // Direction bit appended to the address
   localparam logic       DIR_WRITE  = 1'b0;
   localparam logic       DIR_READ   = 1'b1;
   // Fixed addresses of the two package variants
   localparam logic [6:0] ADDR_VARIANT_A = 7'h60;
   localparam logic [6:0] ADDR_VARIANT_B = 7'h61;
   // Saturation value of the clock-high length counter
   localparam logic [7:0] HIGH_CNT_MAX = 8'hFF;

   ////////////////////////////////////////////////////////////////////////
   // Types

   // Transfer state, Gray along idle, start, byte, stop
   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_START = 2'h1,
      ST_BYTE  = 2'h3,
      ST_STOP  = 2'h2
   } pisp_state_type;

   // Quarter phase of one bit slot, Gray coded
   typedef enum logic [1:0] {
      PH_SET    = 2'h0,
      PH_RISE   = 2'h1,
      PH_SAMPLE = 2'h3,
      PH_FALL   = 2'h2
   } pisp_phase_type;

   // Which byte of the transfer is on the wire
   typedef enum logic [2:0] {
      BY_ADDRW = 3'h0,
      BY_INDEX = 3'h1,
      BY_WDATA = 3'h3,
      BY_ADDRR = 3'h2,
      BY_RDATA = 3'h6
   } pisp_byte_type;

endpackage

`default_nettype wire

// ### hw/pisp_sync2.sv
// Two flip-flop synchroniser for a single level
`default_nettype none

module pisp_sync2 #(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Level in and synchronised level out
   input  wire logic d,
   output var  logic q
);

   // First stage, read only by the second stage
   logic meta;

   // Both stages take the reset constant, then shift the input through
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RESET_VAL;
         q    <= RESET_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

`default_nettype wire

// ### hw/pisp_tick_gen.sv
// Divider that yields a one-cycle tick every DIV clock cycles
`default_nettype none

module pisp_tick_gen #(
   parameter int DIV = 4
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // One-cycle pulse
   output var  logic tick
);

   localparam int           W    = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   // Free-running cycle count within one period
   logic [W-1:0] count;

   // Wrap at the last count and pulse the tick there
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (count == LAST) begin
         count <= '0;
         tick  <= 1'b1;
      end else begin
         count <= count + 1'b1;
         tick  <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ### hw/pisp_host.sv
// Host-side two-wire bus master for register access to the power device
`default_nettype none

module pisp_host (
   // System clock and reset
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   // Command from user logic
   input  wire logic       cmd_valid,
   input  wire logic       cmd_read,
   input  wire logic       cmd_variant,
   input  wire logic [7:0] cmd_index,
   input  wire logic [7:0] cmd_wdata,
   output var  logic       cmd_ready,
   // Result to user logic
   output var  logic       rsp_done,
   output var  logic       rsp_nack,
   output var  logic [7:0] rsp_rdata,
   output var  logic       bus_busy,
   // Serial clock pin, open drain
   input  wire logic       scl_i,
   output var  logic       scl_o,
   output var  logic       scl_oe,
   // Serial data pin, open drain
   input  wire logic       sda_i,
   output var  logic       sda_o,
   output var  logic       sda_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Reset, pin synchronisers and bit timing

   logic rst_n;   // Reset released through two flip-flops
   logic scl_s;   // Clock line level, synchronised
   logic sda_s;   // Data line level, synchronised
   logic tick;    // One pulse per quarter bit

   // Asserts at once, releases two edges after resetn rises
   pisp_sync2 #(.RESET_VAL(1'b0)) u_rst_sync (
      .clk   (sys_clk),
      .rst_n (resetn),
      .d     (1'b1),
      .q     (rst_n)
   );

   // The wire levels come from outside and must be synchronised
   pisp_sync2 #(.RESET_VAL(1'b1)) u_scl_sync (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .d     (scl_i),
      .q     (scl_s)
   );

   pisp_sync2 #(.RESET_VAL(1'b1)) u_sda_sync (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .d     (sda_i),
      .q     (sda_s)
   );

   // Quarter-bit divider; four quarters keep the rate at or below max
   pisp_tick_gen #(.DIV(pisp_pkg::QUARTER_CYCLES)) u_tick (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .tick  (tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // State

   pisp_pkg::pisp_state_type state;       // Transfer state
   pisp_pkg::pisp_state_type next_state;
   pisp_pkg::pisp_phase_type phase;       // Quarter within a bit slot
   pisp_pkg::pisp_phase_type next_phase;
   pisp_pkg::pisp_byte_type  byte_sel;    // Byte now on the wire
   pisp_pkg::pisp_byte_type  next_sel;
   logic [3:0]               bit_cnt;     // Slot 0..7 data, 8 ack
   logic [3:0]               next_bit;
   logic                     rd_q;        // Latched direction of job
   logic                     variant_q;   // Latched address variant
   logic [7:0]               index_q;     // Latched register index
   logic [7:0]               wdata_q;     // Latched write data
   logic [7:0]               rx_byte;     // Bits read from the slave
   logic                     ack_bit;     // Level seen in ack slot

   ////////////////////////////////////////////////////////////////////////
   // Decode

   logic       accept;      // Command taken this cycle
   logic       stall;       // Slave holds the clock low
   logic       step;        // Advance one quarter
   logic       at_ack;      // Current slot is the ack slot
   logic       rx_mode;     // Slave is sending this byte
   logic       slot_end;    // Last quarter of a slot is done
   logic       byte_end;    // Ack slot has just finished
   logic       nack_seen;   // Slave refused the byte
   logic [6:0] dev_addr;    // Address of the chosen variant
   logic [7:0] tx_byte;     // Byte the master sends now
   logic       tx_bit;      // Bit of tx_byte for this slot
   logic       drive_bit;   // Data line pulled low in this slot
   logic       next_scl_oe;
   logic       next_sda_oe;

   assign accept   = cmd_valid & cmd_ready;
   // Sampling waits until the clock line really is high
   assign stall    = (phase == pisp_pkg::PH_SAMPLE) & ~scl_s;
   assign step     = tick & ~stall & (state != pisp_pkg::ST_IDLE);
   assign at_ack   = (bit_cnt == pisp_pkg::ACK_SLOT);
   assign rx_mode  = (byte_sel == pisp_pkg::BY_RDATA);
   assign slot_end = step & (phase == pisp_pkg::PH_FALL);
   assign byte_end = slot_end & (state == pisp_pkg::ST_BYTE) & at_ack;
   // Refusal ends the job; the read byte is refused by us, not it
   assign nack_seen = byte_end & ~rx_mode & ack_bit;

   // One of the two fixed addresses
   assign dev_addr = variant_q ? pisp_pkg::ADDR_VARIANT_B
                               : pisp_pkg::ADDR_VARIANT_A;

   // Byte order: address+W, index, data; or address+R after index
   assign tx_byte =
      (byte_sel == pisp_pkg::BY_ADDRW) ?
         {dev_addr, pisp_pkg::DIR_WRITE} :
      (byte_sel == pisp_pkg::BY_ADDRR) ?
         {dev_addr, pisp_pkg::DIR_READ} :
      (byte_sel == pisp_pkg::BY_INDEX) ? index_q :
      wdata_q;

   // Slot 0 carries bit 7; inverted count picks msb first
   assign tx_bit    = tx_byte[~bit_cnt[2:0]];
   // Ack slot: release for the slave, and release as our refusal
   assign drive_bit = ~at_ack & ~rx_mode & ~tx_bit;

   // Clock: released on rise, pulled low on fall, left free after stop
   assign next_scl_oe =
      (phase == pisp_pkg::PH_RISE) ? 1'b0 :
      (phase == pisp_pkg::PH_FALL && state != pisp_pkg::ST_STOP) ? 1'b1 :
      scl_oe;

   // Data moves while clock low, except the start and stop edges
   assign next_sda_oe =
      (phase == pisp_pkg::PH_SET) ?
         ((state == pisp_pkg::ST_START) ? 1'b0 :
          (state == pisp_pkg::ST_STOP)  ? 1'b1 : drive_bit) :
      (phase == pisp_pkg::PH_SAMPLE) ?
         ((state == pisp_pkg::ST_START) ? 1'b1 :
          (state == pisp_pkg::ST_STOP)  ? 1'b0 :
          sda_oe) :
      sda_oe;

   // Phase walks Gray: set, rise, sample, fall
   assign next_phase =
      accept ? pisp_pkg::PH_SET :
      !step  ? phase :
      (phase == pisp_pkg::PH_SET)    ? pisp_pkg::PH_RISE :
      (phase == pisp_pkg::PH_RISE)   ? pisp_pkg::PH_SAMPLE :
      (phase == pisp_pkg::PH_SAMPLE) ? pisp_pkg::PH_FALL :
      pisp_pkg::PH_SET;

   ////////////////////////////////////////////////////////////////////////
   // Transfer sequencing

   // Next state, byte and slot
   always_comb begin
      next_state = state;
      next_sel   = byte_sel;
      next_bit   = bit_cnt;
      unique case (state)
         pisp_pkg::ST_IDLE: begin
            // A new job always opens with a start
            if (accept) begin
               next_state = pisp_pkg::ST_START;
               next_sel   = pisp_pkg::BY_ADDRW;
            end
         end
         pisp_pkg::ST_START: begin
            // Same start sequence serves first and repeated start
            if (slot_end) begin
               next_state = pisp_pkg::ST_BYTE;
               next_bit   = pisp_pkg::FIRST_SLOT;
            end
         end
         pisp_pkg::ST_BYTE: begin
            if (slot_end && !at_ack) begin
               next_bit = bit_cnt + pisp_pkg::SLOT_STEP;
            end else if (nack_seen) begin
               // No acknowledge: give the bus back at once
               next_state = pisp_pkg::ST_STOP;
            end else if (byte_end) begin
               next_bit = pisp_pkg::FIRST_SLOT;
               unique case (byte_sel)
                  pisp_pkg::BY_ADDRW: begin
                     next_sel = pisp_pkg::BY_INDEX;
                  end
                  pisp_pkg::BY_INDEX: begin
                     // A read turns round with a repeated start
                     if (rd_q) begin
                        next_state = pisp_pkg::ST_START;
                        next_sel   = pisp_pkg::BY_ADDRR;
                     end else begin
                        next_sel = pisp_pkg::BY_WDATA;
                     end
                  end
                  pisp_pkg::BY_ADDRR: begin
                     next_sel = pisp_pkg::BY_RDATA;
                  end
                  pisp_pkg::BY_WDATA, pisp_pkg::BY_RDATA: begin
                     next_state = pisp_pkg::ST_STOP;
                  end
                  default: begin
                     next_state = pisp_pkg::ST_STOP;
                  end
               endcase
            end
         end
         pisp_pkg::ST_STOP: begin
            if (slot_end) begin
               next_state = pisp_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= pisp_pkg::ST_IDLE;
         phase    <= pisp_pkg::PH_SET;
         byte_sel <= pisp_pkg::BY_ADDRW;
         bit_cnt  <= pisp_pkg::FIRST_SLOT;
      end else begin
         state    <= next_state;
         phase    <= next_phase;
         byte_sel <= next_sel;
         bit_cnt  <= next_bit;
      end
   end

   // Command latch; held for the whole job
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q      <= 1'b0;
         variant_q <= 1'b0;
         index_q   <= 8'h00;
         wdata_q   <= 8'h00;
      end else if (accept) begin
         rd_q      <= cmd_read;
         variant_q <= cmd_variant;
         index_q   <= cmd_index;
         wdata_q   <= cmd_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line drivers and sampling

   // Open-drain enables change only on a quarter step
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else if (step) begin
         scl_oe <= next_scl_oe;
         sda_oe <= next_sda_oe;
      end
   end

   // Pins are only ever pulled low; the level comes from the pull-ups
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end
   end

   // Sample the data line in the middle of the clock-high time
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_byte <= 8'h00;
         ack_bit <= 1'b1;
      end else if (step && phase == pisp_pkg::PH_SAMPLE &&
                   state == pisp_pkg::ST_BYTE) begin
         if (at_ack) begin
            ack_bit <= sda_s;
         end else begin
            rx_byte <= {rx_byte[6:0], sda_s};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Results to user logic

   // Ready only while idle; a job cannot be queued behind another
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_ready <= 1'b0;
         rsp_done  <= 1'b0;
      end else begin
         cmd_ready <= (next_state == pisp_pkg::ST_IDLE);
         rsp_done  <= slot_end & (state == pisp_pkg::ST_STOP);
      end
   end

   // Refusal flag lives until the next job; read byte kept on success
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_nack  <= 1'b0;
         rsp_rdata <= 8'h00;
      end else begin
         if (nack_seen) begin
            rsp_nack <= 1'b1;
         end else if (accept) begin
            rsp_nack <= 1'b0;
         end
         if (byte_end && rx_mode) begin
            rsp_rdata <= rx_byte;
         end
      end
   end

   // Busy from the start edge to the stop edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_busy <= 1'b0;
      end else if (step && phase == pisp_pkg::PH_SAMPLE) begin
         if (state == pisp_pkg::ST_START) begin
            bus_busy <= 1'b1;
         end else if (state == pisp_pkg::ST_STOP) begin
            bus_busy <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   localparam int HIGH_MIN = pisp_pkg::QUARTER_CYCLES;

   // Cycles the clock line has been released; the high time of a start
   // counts too, so the first pull-down of a byte is judged fairly
   logic [7:0] hi_cnt;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_cnt <= 8'h00;
      end else if (scl_oe) begin
         hi_cnt <= 8'h00;
      end else if (hi_cnt != pisp_pkg::HIGH_CNT_MAX) begin
         hi_cnt <= hi_cnt + 8'h01;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Ack slot of the read byte, followed by the stop
   sequence s_refuse_slot;
      state == pisp_pkg::ST_BYTE && rx_mode && at_ack &&
      phase == pisp_pkg::PH_SAMPLE;
   endsequence

   sequence s_stop_low;
      state == pisp_pkg::ST_STOP && sda_oe;
   endsequence

   a_data_stable:
      assert property ((state == pisp_pkg::ST_BYTE && !scl_oe &&
                        $past(!scl_oe)) |-> $stable(sda_oe))
      else $error("data moved while clock high");

   a_start_edge:
      assert property ((state == pisp_pkg::ST_START && $rose(sda_oe))
                       |-> !scl_oe && bus_busy)
      else $error("start edge not taken with clock high");

   a_stop_edge:
      assert property ((state == pisp_pkg::ST_STOP && $fell(sda_oe))
                       |-> !scl_oe ##1 !bus_busy)
      else $error("stop edge not taken with clock high");

   a_master_cond:
      assert property ((!scl_oe && $changed(sda_oe)) |->
                       (state == pisp_pkg::ST_START ||
                        state == pisp_pkg::ST_STOP))
      else $error("data edge under high clock outside start or stop");

   a_msb_first:
      assert property ((state == pisp_pkg::ST_BYTE && !rx_mode &&
                        bit_cnt == pisp_pkg::FIRST_SLOT &&
                        phase == pisp_pkg::PH_RISE) |->
                       sda_oe == !tx_byte[7])
      else $error("first slot did not carry bit 7");

   a_ack_release:
      assert property ((state == pisp_pkg::ST_BYTE && at_ack &&
                        phase == pisp_pkg::PH_RISE) |-> !sda_oe)
      else $error("master held data in the ack slot");

   a_ack_clocked:
      assert property ($rose(state == pisp_pkg::ST_BYTE && at_ack)
                       |-> ##[1:300] !scl_oe)
      else $error("no clock pulse for the ack slot");

   a_dir_bit:
      assert property ((state == pisp_pkg::ST_BYTE &&
                        (byte_sel == pisp_pkg::BY_ADDRW ||
                         byte_sel == pisp_pkg::BY_ADDRR) &&
                        bit_cnt == 4'h7 && phase == pisp_pkg::PH_RISE)
                       |-> sda_oe == (byte_sel == pisp_pkg::BY_ADDRW))
      else $error("direction bit wrong");

   a_index_second:
      assert property ($rose(byte_sel == pisp_pkg::BY_INDEX) |->
                       $past(byte_sel) == pisp_pkg::BY_ADDRW)
      else $error("index byte not second");

   a_read_after_index:
      assert property ($rose(byte_sel == pisp_pkg::BY_ADDRR) |->
                       $past(byte_sel) == pisp_pkg::BY_INDEX &&
                       state == pisp_pkg::ST_START)
      else $error("read address without index write");

   a_clock_high_len:
      assert property ((state == pisp_pkg::ST_BYTE && $rose(scl_oe))
                       |-> $past(hi_cnt) >= HIGH_MIN)
      else $error("clock high time too short for the bit rate");

   a_refuse_stop:
      assert property (s_refuse_slot |-> !sda_oe ##[1:600] s_stop_low)
      else $error("read byte not refused then stopped");

endmodule

`default_nettype wire

// ### testbench/pisp_dev_model.sv
// Behavioural model of the power device's two-wire slave port
`default_nettype none
module pisp_dev_model #(
   parameter logic [6:0] ADDR = 7'h60
) (
   // Wire levels
   input  wire logic scl,
   input  wire logic sda,
   // Data pull-down enable
   output var  logic sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] regs [256];  // Register file
   logic [7:0] sh, tx, idx; // Shifters and index
   int         bitn, byten; // Slot and byte counts
   logic       act, rd_pend, rd_ph;
   initial sda_oe = 1'b0;
   // Start or repeated start restarts the byte count
   always @(negedge sda) if (scl) begin
      {bitn, byten, act, rd_pend, rd_ph} = '0;
      act = 1'b1;
   end
   // Stop frees the bus
   always @(posedge sda) if (scl) begin
      act = 1'b0;
      sda_oe = 1'b0;
   end
   // Sample while the clock is high
   always @(posedge scl) if (act) begin
      sh = {sh[6:0], sda};
      bitn++;
   end
   // Drive only after the clock falls, so data is stable when high
   always @(negedge scl) if (act) begin
      if (bitn == 9) begin
         bitn = 0;
         byten++;
         sda_oe = 1'b0;
         if (rd_pend && !rd_ph) begin
            rd_ph = 1'b1;
            tx = regs[idx];
            sda_oe = ~tx[7];
            tx = {tx[6:0], 1'b0};
         end
      end else if (rd_ph) begin
         sda_oe = (bitn == 8) ? 1'b0 : ~tx[7];
         tx = {tx[6:0], 1'b0};
      end else if (bitn == 8) begin
         if (byten == 0 && sh[7:1] != ADDR) begin
            act = 1'b0;
         end else begin
            if (byten == 0) rd_pend = sh[0];
            if (byten == 1) idx = sh;
            if (byten == 2) regs[idx] = sh;
            sda_oe = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the host-side two-wire master
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk, resetn, cmd_valid, cmd_read, cmd_variant;
   logic [7:0] cmd_index, cmd_wdata, rsp_rdata;
   logic       cmd_ready, rsp_done, rsp_nack, bus_busy;
   logic       scl_oe, sda_oe, dev_oe, hold, scl_o, sda_o;
   // Pulled up unless held low; hold stretches the clock like a slave
   wire        scl = ~(scl_oe | hold);
   wire        sda = ~(sda_oe | dev_oe);
   int         error_cnt, tests_run, cyc, starts, stops;

   pisp_host pisp_host_inst (
      .sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid),
      .cmd_read(cmd_read), .cmd_variant(cmd_variant),
      .cmd_index(cmd_index), .cmd_wdata(cmd_wdata),
      .cmd_ready(cmd_ready), .rsp_done(rsp_done), .rsp_nack(rsp_nack),
      .rsp_rdata(rsp_rdata), .bus_busy(bus_busy), .scl_i(scl),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe));
   // Device answers at the first variant only
   pisp_dev_model #(.ADDR(7'h60)) pisp_dev_model_inst (
      .scl(scl), .sda(sda), .sda_oe(dev_oe));

   ///////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Wire-level start and stop counts
   always @(negedge sda) if (scl === 1'b1) starts++;
   always @(posedge sda) if (scl === 1'b1) stops++;
   // Hang guard, well above eight jobs
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 90000) begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask

   // One job, held until taken, then waits for its done pulse
   task automatic job(input logic rd, input logic vs,
                      input logic [7:0] ix, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_read <= rd;
      cmd_variant <= vs;
      cmd_index <= ix;
      cmd_wdata <= wd;
      do begin
         @(posedge sys_clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 100);
      if (n >= 100) check(1'b0, 1'b1);
      cmd_valid <= 1'b0;
      repeat (300) @(posedge sys_clk);
      check(bus_busy, 1'b1);
      do begin
         @(posedge sys_clk);
         n++;
      end while (rsp_done !== 1'b1 && n < 20000);
      if (n >= 20000) check(1'b0, 1'b1);
      check(bus_busy, 1'b0);
   endtask

   task automatic t_reset;
      // Ready shows after the third edge, so look one edge later
      repeat (4) @(posedge sys_clk);
      check(cmd_ready, 1'b1);
      check(bus_busy, 1'b0);
      check({scl, sda}, 2'h3);
      check({scl_o, sda_o}, 2'h0);
      $display("reset test done");
   endtask

   task automatic t_wr_rd;
      {starts, stops} = '0;
      job(1'b0, 1'b0, 8'h23, 8'h5A);
      check(pisp_dev_model_inst.regs[8'h23], 8'h5A);
      check({starts[3:0], stops[3:0]}, 8'h11);
      check(rsp_nack, 1'b0);
      job(1'b1, 1'b0, 8'h23, 8'h00);
      check(rsp_rdata, 8'h5A);
      check({starts[3:0], stops[3:0]}, 8'h32);
      $display("write-read test done");
   endtask

   task automatic t_index;
      job(1'b0, 1'b0, 8'h24, 8'hA5);
      job(1'b0, 1'b0, 8'h23, 8'h3C);
      job(1'b1, 1'b0, 8'h24, 8'h00);
      check(rsp_rdata, 8'hA5);
      $display("index test done");
   endtask

   // Other address must be refused and leave the registers alone
   task automatic t_foreign;
      job(1'b0, 1'b1, 8'h24, 8'h00);
      check(rsp_nack, 1'b1);
      job(1'b1, 1'b0, 8'h24, 8'h00);
      check(rsp_nack, 1'b0);
      check(rsp_rdata, 8'hA5);
      $display("address test done");
   endtask

   // Hold the clock wire low for a while; the master must wait for it
   task automatic t_stretch;
      fork
         job(1'b0, 1'b0, 8'h25, 8'hC3);
         begin
            repeat (1000) @(posedge sys_clk);
            @(posedge scl_oe);
            @(posedge sys_clk);
            hold <= 1'b1;
            repeat (400) @(posedge sys_clk);
            hold <= 1'b0;
         end
      join
      check(pisp_dev_model_inst.regs[8'h25], 8'hC3);
      check(rsp_nack, 1'b0);
      $display("stretch test done");
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      {resetn, cmd_valid, cmd_read, cmd_variant, hold} = '0;
      {cmd_index, cmd_wdata} = '0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      t_reset();
      t_wr_rd();
      t_index();
      t_foreign();
      t_stretch();
      end_sim();
   end
endmodule
`default_nettype wire
